// ===== design/wtsp_sched.sv
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ns

// Summary of operation
// [RQ1] Weekday mask: Monday bit 0 through Sunday bit 6.
// [RQ2] Several mask bits may be set; timer starts on every selected day.
// [RQ3] Four independent timers, each with mode, start, end and mask.
// [RQ4] Twenty pause entries, each stored and matched on its own.
// [RQ5] A matching enabled pause entry suppresses all timer operation.
// [RQ6] Pause entry bit 15 enables it; when clear it never matches.
// [RQ7] Pause bit 13 picks month-day format (1) or week-weekday format (0).
// [RQ8] Month field must equal the current month in both formats.
// [RQ9] Middle field is day 1 to 31, or week 1 to 4 or final.
// [RQ10] Weekday format: low bits give Monday to Sunday, matched with month and week.
// [RQ11] Pause entries are 16-bit unsigned and accept any value.
// [RQ12] Mode 0 off, 1 run request, 2 output flags, 3 both.
// [RQ13] Start before end runs same day; otherwise runs into next day's end time.
// [RQ14] Common in-operation flag plus one flag per timer in output modes.
// [RQ15] Final-week entry matches the last such weekday of the month.
module wtsp_sched #(
  parameter int unsigned NUM_TIMERS = wtsp_pkg::NUM_TIMERS,
  parameter int unsigned NUM_PAUSE  = wtsp_pkg::NUM_PAUSE
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Calendar from the real-time clock logic, same clock domain
  input  wire logic [3:0]            cal_month,
  input  wire logic [4:0]            cal_day,
  input  wire logic [2:0]            cal_weekday,
  input  wire logic [4:0]            cal_days_in_month,
  input  wire logic [10:0]           cal_minute,
  // Outputs toward run control and digital outputs
  output logic                       run_request,
  output logic                       schedule_active_flag,
  output logic [NUM_TIMERS-1:0]      timer_enabled_flags,
  output logic                       pause_day_active
);

  // All module state in one packed struct
  typedef struct packed {
    logic [NUM_TIMERS-1:0][1:0]                mode;
    logic [NUM_TIMERS-1:0][6:0]                mask;
    logic [NUM_TIMERS-1:0][wtsp_pkg::MIN_W-1:0] t_start;
    logic [NUM_TIMERS-1:0][wtsp_pkg::MIN_W-1:0] t_end;
    logic [NUM_PAUSE-1:0][wtsp_pkg::PAUSE_W-1:0] pause;
    logic                                      run;
    logic                                      active;
    logic                                      paused;
    logic [NUM_TIMERS-1:0]                     flags;
    logic [31:0]                               rdata;
    logic                                      err;
  } wtsp_state_s;

  wtsp_state_s state_q;
  wtsp_state_s state_d;

  logic [NUM_TIMERS-1:0] tmr_on;
  logic [NUM_PAUSE-1:0]  pause_hit;
  logic [6:0]            today_bit;
  logic [6:0]            yesterday_bit;
  logic [2:0]            week_of_month;
  logic                  last_week;

  // Today and yesterday as one-hot weekday bits, Monday = 0
  always_comb begin
    today_bit     = 7'h01 << cal_weekday; // RQ1
    yesterday_bit = (cal_weekday == 3'h0) ? 7'h40 : (7'h01 << (cal_weekday - 3'h1));
  end

  // Week position of the current day within its month
  always_comb begin
    week_of_month = 3'((5'(cal_day - 5'h01) / 5'h07) + 5'h01);
    last_week     = (6'(cal_day) + 6'h07) > 6'(cal_days_in_month); // RQ15
  end

  // Per-timer window decode
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
    logic after_start;
    logic before_end;
    logic on_today;
    logic from_yday;
    always_comb begin
      after_start = cal_minute >= state_q.t_start[t];
      before_end  = cal_minute < state_q.t_end[t];
      on_today    = |(state_q.mask[t] & today_bit); // RQ2
      from_yday   = |(state_q.mask[t] & yesterday_bit);
      if (state_q.t_start[t] < state_q.t_end[t]) begin // RQ13
        tmr_on[t] = on_today && after_start && before_end;
      end else begin
        tmr_on[t] = (on_today && after_start) || (from_yday && before_end); // RQ13
      end
    end
  end

  // Per-entry pause date match
  for (genvar p = 0; p < NUM_PAUSE; p++) begin : g_pause
    logic [15:0] ent;
    logic [3:0]  ent_mon;
    logic [4:0]  ent_mid;
    logic [2:0]  ent_wd;
    logic        week_ok;
    always_comb begin
      ent     = state_q.pause[p]; // RQ11
      ent_mon = ent[wtsp_pkg::PE_MON_LSB +: 4]; // RQ8
      ent_mid = ent[wtsp_pkg::PE_DAY_LSB +: 5]; // RQ9
      ent_wd  = ent[wtsp_pkg::PE_WD_LSB +: 3]; // RQ10
      week_ok = (ent_mid == wtsp_pkg::WEEK_FINAL) ? last_week // RQ15
                : (ent_mid == 5'(week_of_month));
      pause_hit[p] = 1'b0;
      if (ent[wtsp_pkg::PE_EN_BIT] && (ent_mon == cal_month)) begin // RQ6 RQ8
        if (ent[wtsp_pkg::PE_FMT_BIT]) begin // RQ7
          pause_hit[p] = (ent_mid == cal_day); // RQ9
        end else begin
          pause_hit[p] = week_ok && (ent_wd == (cal_weekday + 3'h1)); // RQ10
        end
      end
    end
  end

  // Next-state: register writes, read capture, schedule outputs
  always_comb begin
    logic        paused_now;
    logic        any_run;
    logic        setup;
    logic [7:0]  rel;
    logic [31:0] rd;
    logic        hit;
    paused_now = |pause_hit; // RQ4 RQ5
    any_run    = 1'b0;
    setup      = psel && !penable;
    rel        = 8'h00;
    rd         = 32'h0000_0000;
    hit        = 1'b0;
    state_d    = state_q;

    // Mode gating of each timer, all held off on a pause day
    for (int t = 0; t < NUM_TIMERS; t++) begin
      state_d.flags[t] = !paused_now && tmr_on[t] && state_q.mode[t][1]; // RQ12 RQ14 RQ5
      any_run = any_run || (!paused_now && tmr_on[t] && state_q.mode[t][0]); // RQ12
    end
    state_d.run    = any_run;
    state_d.active = |state_d.flags; // RQ14
    state_d.paused = paused_now;

    // Timer registers
    for (int t = 0; t < NUM_TIMERS; t++) begin
      rel = 8'(paddr - (wtsp_pkg::TMR_BASE + 8'(t) * wtsp_pkg::TMR_STRIDE));
      if (paddr >= 8'(wtsp_pkg::TMR_BASE + 8'(t) * wtsp_pkg::TMR_STRIDE) &&
          rel < wtsp_pkg::TMR_STRIDE) begin
        unique case (rel)
          wtsp_pkg::TMR_CTRL_OFS: begin
            hit = 1'b1;
            rd  = {17'h0, state_q.mask[t], 6'h0, state_q.mode[t]};
            if (psel && penable && pwrite) begin
              state_d.mode[t] = pwdata[wtsp_pkg::MODE_LSB +: 2]; // RQ3
              state_d.mask[t] = pwdata[wtsp_pkg::MASK_LSB +: 7]; // RQ1
            end
          end
          wtsp_pkg::TMR_START_OFS: begin
            hit = 1'b1;
            rd  = {21'h0, state_q.t_start[t]};
            if (psel && penable && pwrite) begin
              state_d.t_start[t] = pwdata[wtsp_pkg::MIN_W-1:0];
            end
          end
          wtsp_pkg::TMR_END_OFS: begin
            hit = 1'b1;
            rd  = {21'h0, state_q.t_end[t]};
            if (psel && penable && pwrite) begin
              state_d.t_end[t] = pwdata[wtsp_pkg::MIN_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Pause entries
    for (int p = 0; p < NUM_PAUSE; p++) begin
      if (paddr == 8'(wtsp_pkg::PAUSE_BASE + 8'(p) * 8'h04)) begin
        hit = 1'b1;
        rd  = {16'h0, state_q.pause[p]};
        if (psel && penable && pwrite) begin
          state_d.pause[p] = pwdata[wtsp_pkg::PAUSE_W-1:0]; // RQ11
        end
      end
    end

    // Status word, read only
    if (paddr == wtsp_pkg::STATUS_OFS) begin
      hit = 1'b1;
      rd  = 32'h0000_0000;
      rd[wtsp_pkg::ST_RUN_BIT]   = state_q.run;
      rd[wtsp_pkg::ST_ACT_BIT]   = state_q.active;
      rd[wtsp_pkg::ST_PAUSE_BIT] = state_q.paused;
      rd[wtsp_pkg::ST_FLAG_LSB +: NUM_TIMERS] = state_q.flags;
    end

    // Read data and error captured in the setup cycle
    if (setup) begin
      state_d.rdata = pwrite ? 32'h0000_0000 : rd;
      state_d.err   = !hit || (pwrite && (paddr == wtsp_pkg::STATUS_OFS));
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Zero-wait APB answer, pready and pslverr gated by psel and penable; prdata and schedule outputs straight from flops
  assign pready               = psel && penable;
  assign prdata               = state_q.rdata;
  assign pslverr              = psel && penable && state_q.err;
  assign run_request          = state_q.run;
  assign schedule_active_flag = state_q.active; // RQ14
  assign timer_enabled_flags  = state_q.flags;
  assign pause_day_active     = state_q.paused;

endmodule : wtsp_sched

// ===== pkg/wtsp_pkg.sv
// Shared constants for the weekly timer scheduler
package wtsp_pkg;

  // Structure sizes
  localparam int unsigned NUM_TIMERS   = 4;
  localparam int unsigned NUM_PAUSE    = 20;
  localparam int unsigned MIN_W        = 11;
  localparam int unsigned PAUSE_W      = 16;

  // Register map, byte addresses
  localparam logic [7:0] TMR_BASE      = 8'h00;
  localparam logic [7:0] TMR_STRIDE    = 8'h10;
  localparam logic [7:0] TMR_CTRL_OFS  = 8'h00;
  localparam logic [7:0] TMR_START_OFS = 8'h04;
  localparam logic [7:0] TMR_END_OFS   = 8'h08;
  localparam logic [7:0] PAUSE_BASE    = 8'h40;
  localparam logic [7:0] STATUS_OFS    = 8'h90;

  // Timer control word layout
  localparam int unsigned MODE_LSB     = 0;
  localparam int unsigned MASK_LSB     = 8;

  // Pause entry layout
  localparam int unsigned PE_EN_BIT    = 15;
  localparam int unsigned PE_FMT_BIT   = 13;
  localparam int unsigned PE_MON_LSB   = 8;
  localparam int unsigned PE_DAY_LSB   = 3;
  localparam int unsigned PE_WD_LSB    = 0;
  localparam logic [4:0]  WEEK_FINAL   = 5'h05;

  // Status word layout
  localparam int unsigned ST_RUN_BIT   = 0;
  localparam int unsigned ST_ACT_BIT   = 1;
  localparam int unsigned ST_PAUSE_BIT = 2;
  localparam int unsigned ST_FLAG_LSB  = 4;

  // Reset values
  localparam logic [1:0]  MODE_RST     = 2'h0;
  localparam logic [6:0]  MASK_RST     = 7'h00;
  localparam logic [10:0] TIME_RST     = 11'h000;
  localparam logic [15:0] PAUSE_RST    = 16'h0000;

  // Timer operating modes
  typedef enum logic [1:0] {
    WTSP_MODE_OFF  = 2'h0,
    WTSP_MODE_RUN  = 2'h1,
    WTSP_MODE_FLAG = 2'h2,
    WTSP_MODE_BOTH = 2'h3
  } wtsp_mode_e;

endpackage : wtsp_pkg

// ===== bench/wtsp_run_model.sv
`timescale 1ns/1ns
// Far-side run control: motor follows the run command
module wtsp_run_model (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic run_request,
  output logic      motor_on
);
  // Contactor picks up one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) motor_on <= 1'b0;
    else motor_on <= run_request;
  end
endmodule : wtsp_run_model

// ===== bench/wtsp_sched_properties.sv
`timescale 1ns/1ns
// Port relations of the scheduler
module wtsp_sched_chk #(
  parameter int unsigned NUM_TIMERS = 4
) (
  input wire logic                  sys_clk,
  input wire logic                  rst_b,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  run_request,
  input wire logic                  schedule_active_flag,
  input wire logic [NUM_TIMERS-1:0] timer_enabled_flags,
  input wire logic                  pause_day_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Bus phases
  sequence s_setup; psel && !penable; endsequence
  sequence s_acc; psel && penable; endsequence
  property p_flag_or; schedule_active_flag == (|timer_enabled_flags); endproperty
  a_flag_or: assert property (p_flag_or) else $error("common flag");
  property p_pause; pause_day_active |-> !run_request && !schedule_active_flag; endproperty
  a_pause: assert property (p_pause) else $error("pause leak");
  property p_ready; s_setup ##1 s_acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no pready");
  property p_hold; s_acc ##0 !pwrite |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("prdata moved");
  property p_ro; s_acc ##0 pwrite && paddr == wtsp_pkg::STATUS_OFS |-> pslverr; endproperty
  a_ro: assert property (p_ro) else $error("status write taken");
  property p_unmap; s_acc ##0 !pwrite && paddr == 8'hfc |-> pslverr && prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_map; s_acc ##0 paddr inside {8'h40, 8'h8c} |-> !pslverr; endproperty
  a_map: assert property (p_map) else $error("pause entry refused");
  property p_rst; $rose(rst_b) |-> !run_request && !pause_day_active; endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
endmodule : wtsp_sched_chk

bind wtsp_sched wtsp_sched_chk #(.NUM_TIMERS(NUM_TIMERS)) wtsp_sched_chk_i (.*);

// ===== bench/tb_wtsp_sched.sv
`timescale 1ns/1ns
module tb_wtsp_sched;
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        run_request, schedule_active_flag, pause_day_active, motor_on;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  cal_month, timer_enabled_flags;
  logic [4:0]  cal_day, cal_days_in_month;
  logic [2:0]  cal_weekday;
  logic [10:0] cal_minute;
  logic [1:0]  mv;
  int          errors, checked;

  wtsp_sched wtsp_sched_i (.*);
  wtsp_run_model wtsp_run_model_i (.*);

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // One APB transfer, waits for pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    if (!w) chk("prdata", e, prdata);
    chk("pslverr", {31'h0, er}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic cal(input int m, input int d, input int w, input int n, input int mi);
    @(posedge sys_clk);
    cal_month <= 4'(m);
    cal_day <= 5'(d);
    cal_weekday <= 3'(w);
    cal_days_in_month <= 5'(n);
    cal_minute <= 11'(mi);
  endtask : cal

  // Expect {run, common, flags, pause}; motor mirrors run
  task automatic out(input logic [6:0] e);
    repeat (3) @(posedge sys_clk);
    chk("outputs", {24'h0, e[6], e}, {24'h0, motor_on, run_request,
        schedule_active_flag, timer_enabled_flags, pause_day_active});
  endtask : out

  task automatic finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    finish_test();
  end

  // Test sequence
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cal_month, cal_day, cal_weekday, cal_days_in_month, cal_minute} = '0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    out(7'h00);
    xfer(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
    xfer(1'b0, 8'h40, 32'h0, 32'h0, 1'b0);
    $display("reset test done");
    cal(5, 10, 2, 31, 150);
    for (int t = 0; t < 4; t++) begin
      wr(8'(16 * t + 4), 32'd100);
      wr(8'(16 * t + 8), 32'd200);
      for (int m = 0; m < 4; m++) begin
        mv = 2'(m);
        wr(8'(16 * t), {17'h0, 7'h7f, 6'h0, mv});
        out({mv[0], mv[1], mv[1] ? 4'(1 << t) : 4'h0, 1'b0});
      end
      wr(8'(16 * t), 32'h0);
    end
    wr(8'h00, {17'h0, 7'h45, 6'h0, 2'h3});
    for (int w = 0; w < 7; w++) begin
      cal(5, 10, w, 31, 150);
      out((7'h45 >> w) & 7'h01 ? 7'h62 : 7'h00);
    end
    cal(5, 10, 0, 31, 250);
    out(7'h00);
    $display("timer test done");
    wr(8'h04, 32'd1200);
    wr(8'h08, 32'd180);
    wr(8'h00, {17'h0, 7'h01, 6'h0, 2'h3});
    cal(5, 17, 1, 31, 100);
    out(7'h62);
    cal(5, 17, 1, 31, 1300);
    out(7'h00);
    cal(5, 17, 0, 31, 1300);
    out(7'h62);
    xfer(1'b0, 8'h90, 32'h0, 32'h0000_0013, 1'b0);
    xfer(1'b0, 8'h00, 32'h0, 32'h0000_0103, 1'b0);
    xfer(1'b0, 8'h04, 32'h0, 32'h0000_04b0, 1'b0);
    wr(8'h8c, 32'ha588);
    out(7'h01);
    xfer(1'b0, 8'h90, 32'h0, 32'h0000_0004, 1'b0);
    wr(8'h8c, 32'h2588);
    out(7'h62);
    wr(8'h8c, 32'ha688);
    out(7'h62);
    wr(8'h8c, 32'h0);
    wr(8'h40, 32'h852f);
    cal(5, 24, 6, 30, 1300);
    out(7'h01);
    cal(5, 24, 6, 31, 1300);
    out(7'h00);
    wr(8'h40, 32'h8527);
    out(7'h01);
    cal(5, 24, 5, 31, 1300);
    out(7'h00);
    $display("pause test done");
    wr(8'h44, 32'hffffffff);
    xfer(1'b0, 8'h44, 32'h0, 32'h0000ffff, 1'b0);
    xfer(1'b1, wtsp_pkg::STATUS_OFS, 32'h1, 32'h0, 1'b1);
    xfer(1'b0, 8'hfc, 32'h0, 32'h0, 1'b1);
    $display("register test done");
    finish_test();
  end
endmodule : tb_wtsp_sched
